/* core/snf_cfg.svh */
`ifndef SNF_CFG_SVH
`define SNF_CFG_SVH

// Feature register addresses
`define SNF_FA_LOCK 8'hA0
`define SNF_FA_CFG 8'hB0
`define SNF_FA_STAT 8'hC0
`define SNF_FA_DRV 8'hD0

// Field positions
`define SNF_CMP_POS 1
`define SNF_TB_POS 2
`define SNF_BP_POS 3
`define SNF_XPG_POS 6
`define SNF_OTPL_POS 7
`define SNF_DRV_POS 5

// Reset values: all rows protected by default
`define SNF_LOCK_RST 8'h38
`define SNF_CFG_RST 8'h00

// Opcodes
`define SNF_OP_WREN 8'h06
`define SNF_OP_RESET 8'hFF
`define SNF_OP_SETF 8'h1F
`define SNF_OP_GETF 8'h0F
`define SNF_OP_PGRD 8'h13
`define SNF_OP_LOAD 8'h02
`define SNF_OP_RLOAD 8'h84
`define SNF_OP_PEXE 8'h10
`define SNF_OP_ERASE 8'hD8

// Geometry
`define SNF_PAGE_BYTES 12'h880
`define SNF_BLK_PAGES 64
`define SNF_XPG_LAST 16'h001A
`define SNF_OTP_FIRST 16'h0002

// Timing
`define SNF_CLK_NS 20
`define SNF_ERS_TIME_US 10000
`define SNF_PRG_TIME_US 900
`define SNF_RD_TIME_US 135
`define SNF_RST_TIME_NS 5000
`define SNF_RST_CYC ((`SNF_RST_TIME_NS) / `SNF_CLK_NS)

`endif

/* core/snf_core.sv */
`timescale 1ns/1ps
`include "snf_cfg.svh"

// Summary of operation
// [R1] Host loads the source page into cache before an internal move.
// [R2] Random load: opcode, four dummy bits, 12-bit column, then bytes to cache.
// [R3] Host issues another random load for each non-contiguous run.
// [R4] Host sets write enable before program execute after loading.
// [R5] Erase acts on exactly one 64-page block.
// [R6] Erase without the write enable latch set is ignored.
// [R7] Erase address is eight dummy bits then a 16-bit row.
// [R8] After the row is captured, device stays busy for the erase time.
// [R9] Reset command aborts any operation, standby after recovery time.
// [R10] Protected rows decode from lock register; code 000 none, 111 all.
// [R11] Codes 001-110 protect top or bottom fractions; complement inverts. Code 110 with complement set protects only rows below 0040h here.
// [R12] Program or erase on a protected row is silently ignored.
// [R13] Extra pages: 00h identifier, 01h parameter, 02h-1Ah one-time pages.
// [R14] Extra pages reachable only while the access bit is one.
// [R15] Host programs one-time pages in ascending order.
// [R16] Host enables extra access with set-feature to the configuration register.
// [R17] Once locked, one-time area refuses all programming.
// [R18] Lock: set access and lock bits, write enable, program execute.
// [R19] Access 0 normal; access 1 lock 0 one-time; both set locks.
// [R20] Identifier and parameter pages are factory data, read-only.
// [R21] All 25 one-time pages are full 2176-byte pages.
// [R22] Page read to cache takes eight zero bits then a 16-bit row.
// [R23] Write enable latch clears when program or erase completes or is refused.
module snf_core #(
    parameter int ERS_CYC = (`SNF_ERS_TIME_US * 1000) / `SNF_CLK_NS,
    parameter int PRG_CYC = (`SNF_PRG_TIME_US * 1000) / `SNF_CLK_NS,
    parameter int RD_CYC = (`SNF_RD_TIME_US * 1000) / `SNF_CLK_NS
) (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Serial link from the host
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Non-volatile lock state from the array
    input wire logic otp_lock_nv_i,
    // Array side
    output logic busy_o,
    output snf_pkg::snf_cache_wr_t cache_o,
    output snf_pkg::snf_arr_cmd_t arr_o
);
    import snf_pkg::*;

    localparam int RST_CYC = `SNF_RST_CYC;

    snf_sys_t s_r, s_nxt;
    snf_link_t l_r, l_nxt;
    snf_frame_t f_r, f_nxt;
    logic [7:0] miso_sh_r;
    logic miso_r;
    logic miso_oe_r;
    logic frame_rst_n;
    logic [7:0] rx_byte;
    logic [7:0] feat_byte;

    function automatic logic snf_row_protected(input logic [7:0] lk,
                                               input logic [15:0] row);
        logic [2:0] bp;
        logic [16:0] sz;
        logic hit;
        bp = lk[`SNF_BP_POS +: 3];
        sz = 17'(17'h00400 << (bp - 3'h1));
        if (bp == 3'h0) begin
            hit = 1'b0; // R10
        end else if (bp == 3'h7) begin
            hit = 1'b1;
        end else if (lk[`SNF_CMP_POS] && bp == 3'h6) begin
            hit = row < 16'h0040; // R11
        end else begin
            if (lk[`SNF_TB_POS]) begin
                hit = {1'b0, row} < sz;
            end else begin
                hit = {1'b0, row} >= (17'h10000 - sz);
            end
            if (lk[`SNF_CMP_POS]) begin
                hit = !hit; // R11
            end
        end
        return hit;
    endfunction : snf_row_protected

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bytes shift in on rising edges

    // Frame state clears while chip select is high; the link clock is idle
    assign frame_rst_n = rst_n_i & ~spi_cs_n_i;
    assign rx_byte = {f_r.shift, spi_mosi_i};

    always_comb begin
        f_nxt = f_r;
        f_nxt.shift = rx_byte[6:0];
        f_nxt.bits = f_r.bits + 3'h1;
        if (f_r.bits == 3'h7) begin
            if (f_r.idx == 2'h0) begin
                f_nxt.op = rx_byte;
            end
            if (f_r.idx == 2'h1) begin
                f_nxt.fa = rx_byte;
            end
            if (f_r.idx != 2'h3) begin
                f_nxt.idx = f_r.idx + 2'h1;
            end
        end
    end

    always_ff @(posedge spi_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

    // Two alternating buffers give the system side sixteen link clocks
    always_comb begin
        l_nxt = l_r;
        l_nxt.mir1 = s_r.mirror;
        l_nxt.mir2 = l_r.mir1;
        if (f_r.bits == 3'h7) begin
            if (l_r.tog) begin
                l_nxt.buf1 = rx_byte;
            end else begin
                l_nxt.buf0 = rx_byte;
            end
            l_nxt.tog = !l_r.tog;
        end
    end

    always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Feature read-back, launched on falling edges
    always_comb begin
        case (f_r.fa)
            `SNF_FA_LOCK: feat_byte = l_r.mir2[31:24];
            `SNF_FA_CFG: feat_byte = l_r.mir2[23:16];
            `SNF_FA_STAT: feat_byte = l_r.mir2[15:8];
            `SNF_FA_DRV: feat_byte = l_r.mir2[7:0];
            default: feat_byte = 8'h00;
        endcase
    end

    always_ff @(negedge spi_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            miso_sh_r <= 8'h00;
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else if (f_r.op == `SNF_OP_GETF && f_r.idx >= 2'h2) begin
            miso_oe_r <= 1'b1;
            if (f_r.bits == 3'h0) begin
                miso_r <= feat_byte[7];
                miso_sh_r <= {feat_byte[6:0], 1'b0};
            end else begin
                miso_r <= miso_sh_r[7];
                miso_sh_r <= {miso_sh_r[6:0], 1'b0};
            end
        end else begin
            miso_oe_r <= 1'b0;
        end
    end

    assign spi_miso_o = miso_r;
    assign spi_miso_oe_o = miso_oe_r;

    ////////////////////////////////////////////////////////////////////////
    // System domain: command decode and sequencing

    always_comb begin
        logic ev;
        logic [7:0] b;
        logic [15:0] row;
        logic idle;
        logic xpg;
        ev = 1'b0;
        b = 8'h00;
        row = 16'h0000;
        idle = 1'b0;
        xpg = 1'b0;
        s_nxt = s_r;
        s_nxt.cs1 = spi_cs_n_i;
        s_nxt.cs2 = s_r.cs1;
        s_nxt.cs3 = s_r.cs2;
        s_nxt.tg1 = l_r.tog;
        s_nxt.tg2 = s_r.tg1;
        s_nxt.tg3 = s_r.tg2;
        s_nxt.nv1 = otp_lock_nv_i;
        s_nxt.nv2 = s_r.nv1;
        s_nxt.cache.we = 1'b0;
        s_nxt.arr.req = 1'b0;
        s_nxt.arr.abort = 1'b0;
        // Lock bit is sticky once seen in the array
        s_nxt.otp_locked = s_r.otp_locked | s_r.nv2; // R18
        ev = s_r.tg2 != s_r.tg3;
        b = s_r.tg2 ? l_r.buf0 : l_r.buf1;
        row = {s_r.hold, b}; // R7 R22
        idle = s_r.state == ST_IDLE;
        xpg = s_r.cfg[`SNF_XPG_POS]; // R14 R19
        // Busy timer
        if (!idle) begin
            if (s_r.tmr == 20'h00000) begin
                if (s_r.state == ST_PROG || s_r.state == ST_ERASE) begin
                    s_nxt.write_enable_latch = 1'b0; // R23
                end
                s_nxt.state = ST_IDLE;
            end else begin
                s_nxt.tmr = s_r.tmr - 20'h00001;
            end
        end
        if (ev) begin
            if (s_r.idx == 2'h0) begin
                s_nxt.op = b;
            end
            if (s_r.idx != 2'h3) begin
                s_nxt.idx = s_r.idx + 2'h1;
            end
            if (s_r.idx == 2'h0 && b == `SNF_OP_RESET) begin
                s_nxt.state = ST_RESET; // R9
                s_nxt.tmr = 20'(RST_CYC - 1);
                s_nxt.write_enable_latch = 1'b0;
                s_nxt.arr.abort = 1'b1;
            end else if (s_r.idx == 2'h0 && b == `SNF_OP_WREN && idle) begin
                s_nxt.write_enable_latch = 1'b1; // R6
            end else if (idle && s_r.idx != 2'h0) begin
                case (s_r.op)
                    `SNF_OP_SETF: begin
                        if (s_r.idx == 2'h1) begin
                            s_nxt.faddr = b;
                        end else if (s_r.idx == 2'h2) begin
                            case (s_r.faddr)
                                `SNF_FA_LOCK: s_nxt.lock = b; // R10
                                `SNF_FA_CFG: s_nxt.cfg = b; // R16
                                `SNF_FA_DRV: s_nxt.drv = b[`SNF_DRV_POS +: 2];
                                default: s_nxt.faddr = s_r.faddr;
                            endcase
                        end
                    end
                    `SNF_OP_LOAD, `SNF_OP_RLOAD: begin
                        if (s_r.idx == 2'h1) begin
                            s_nxt.col[11:8] = b[3:0]; // R2
                        end else if (s_r.idx == 2'h2) begin
                            s_nxt.col[7:0] = b;
                        end else if (s_r.col < `SNF_PAGE_BYTES) begin
                            // Bytes past the end of the cache are dropped
                            s_nxt.cache.we = 1'b1; // R2
                            s_nxt.cache.col = s_r.col;
                            s_nxt.cache.data = b;
                            s_nxt.col = s_r.col + 12'h001;
                        end
                    end
                    `SNF_OP_PGRD: begin
                        if (s_r.idx == 2'h2) begin
                            s_nxt.hold = b;
                        end else if (s_r.idx == 2'h3 && s_r.op == s_nxt.op) begin
                            if (!xpg || row <= `SNF_XPG_LAST) begin // R13
                                s_nxt.arr.req = 1'b1; // R22
                                s_nxt.arr.kind = ARR_READ;
                                s_nxt.arr.extra = xpg;
                                s_nxt.arr.row = row;
                                s_nxt.state = ST_READ;
                                s_nxt.tmr = 20'(RD_CYC - 1);
                            end
                        end
                    end
                    `SNF_OP_PEXE: begin
                        if (s_r.idx == 2'h2) begin
                            s_nxt.hold = b;
                        end else if (s_r.idx == 2'h3) begin
                            s_nxt.write_enable_latch = 1'b0; // R23
                            s_nxt.arr.kind = ARR_PROG;
                            s_nxt.arr.extra = xpg;
                            s_nxt.arr.row = row;
                            s_nxt.tmr = 20'(PRG_CYC - 1);
                            if (!s_r.write_enable_latch) begin
                                s_nxt.state = ST_IDLE;
                            end else if (xpg && s_r.cfg[`SNF_OTPL_POS]) begin
                                if (!s_r.otp_locked) begin
                                    s_nxt.arr.req = 1'b1; // R18
                                    s_nxt.arr.kind = ARR_LOCK;
                                    s_nxt.otp_locked = 1'b1;
                                    s_nxt.state = ST_PROG;
                                    s_nxt.write_enable_latch = 1'b1;
                                end
                            end else if (xpg) begin
                                if (!s_r.otp_locked && // R17
                                    row >= `SNF_OTP_FIRST && // R20
                                    row <= `SNF_XPG_LAST) begin // R21
                                    s_nxt.arr.req = 1'b1;
                                    s_nxt.state = ST_PROG;
                                    s_nxt.write_enable_latch = 1'b1;
                                end
                            end else if (!snf_row_protected(s_r.lock, row)) begin
                                s_nxt.arr.req = 1'b1; // R12
                                s_nxt.state = ST_PROG;
                                s_nxt.write_enable_latch = 1'b1;
                            end
                        end
                    end
                    `SNF_OP_ERASE: begin
                        if (s_r.idx == 2'h2) begin
                            s_nxt.hold = b;
                        end else if (s_r.idx == 2'h3) begin
                            s_nxt.write_enable_latch = 1'b0; // R23
                            if (s_r.write_enable_latch && !xpg && // R6
                                !snf_row_protected(s_r.lock, row)) begin // R12
                                s_nxt.arr.req = 1'b1;
                                s_nxt.arr.kind = ARR_ERASE;
                                s_nxt.arr.extra = 1'b0;
                                // Whole block: page bits forced to zero
                                s_nxt.arr.row = {row[15:6], 6'h00}; // R5
                                s_nxt.state = ST_ERASE; // R8
                                s_nxt.tmr = 20'(ERS_CYC - 1);
                                s_nxt.write_enable_latch = 1'b1;
                            end
                        end
                    end
                    default: s_nxt.op = s_r.op;
                endcase
            end
        end
        // Chip select high ends the frame; bytes of this cycle go first
        if (s_r.cs3) begin
            s_nxt.idx = 2'h0;
        end
        s_nxt.busy = s_nxt.state != ST_IDLE;
        s_nxt.mirror = {s_nxt.lock,
                        s_nxt.cfg | {s_nxt.otp_locked, 7'h00},
                        {6'h00, s_nxt.write_enable_latch, s_nxt.busy},
                        {1'b0, s_nxt.drv, 5'h00}};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
            s_r.cs1 <= 1'b1;
            s_r.cs2 <= 1'b1;
            s_r.cs3 <= 1'b1;
            s_r.state <= ST_IDLE;
            s_r.lock <= `SNF_LOCK_RST;
            s_r.cfg <= `SNF_CFG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_o = s_r.busy;
    assign cache_o = s_r.cache;
    assign arr_o = s_r.arr;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence SEQ_RST_ENTER;
        s_r.state != ST_RESET ##1 s_r.state == ST_RESET;
    endsequence

    sequence SEQ_RST_DONE;
        ##[1:300] s_r.state == ST_IDLE;
    endsequence

    AST_ERASE_NEEDS_WEL: assert property (@(posedge clk_sys_i) // R6
        disable iff (!rst_n_i)
        arr_o.req && arr_o.kind == ARR_ERASE |-> $past(s_r.write_enable_latch))
        else $error("erase issued without write enable");

    AST_PROTECTED_ROW: assert property (@(posedge clk_sys_i) // R12
        disable iff (!rst_n_i)
        arr_o.req && !arr_o.extra &&
        (arr_o.kind == ARR_PROG || arr_o.kind == ARR_ERASE)
        |-> !snf_row_protected($past(s_r.lock), arr_o.row))
        else $error("program or erase reached a protected row");

    AST_ERASE_BUSY: assert property (@(posedge clk_sys_i) // R8
        disable iff (!rst_n_i)
        arr_o.req && arr_o.kind == ARR_ERASE |-> busy_o [*8])
        else $error("erase did not hold busy");

    AST_ERASE_BLOCK: assert property (@(posedge clk_sys_i) // R5
        disable iff (!rst_n_i)
        arr_o.req && arr_o.kind == ARR_ERASE |-> arr_o.row[5:0] == 6'h00)
        else $error("erase row not block aligned");

    AST_RESET_ABORT: assert property (@(posedge clk_sys_i) // R9
        disable iff (!rst_n_i)
        SEQ_RST_ENTER |-> arr_o.abort && !s_r.write_enable_latch ##0 SEQ_RST_DONE)
        else $error("reset did not abort and recover");

    AST_WEL_DROPS: assert property (@(posedge clk_sys_i) // R23
        disable iff (!rst_n_i)
        ($past(s_r.state) == ST_PROG || $past(s_r.state) == ST_ERASE) &&
        s_r.state == ST_IDLE |-> !s_r.write_enable_latch)
        else $error("write enable survived completion");

    AST_OTP_LOCKED: assert property (@(posedge clk_sys_i) // R17
        disable iff (!rst_n_i)
        arr_o.req && arr_o.extra && arr_o.kind == ARR_PROG
        |-> !$past(s_r.otp_locked) && arr_o.row >= `SNF_OTP_FIRST)
        else $error("one-time area programmed while locked");

    AST_EXTRA_GATE: assert property (@(posedge clk_sys_i) // R14
        disable iff (!rst_n_i)
        arr_o.req && arr_o.extra |-> $past(s_r.cfg[`SNF_XPG_POS]) &&
        arr_o.row <= `SNF_XPG_LAST)
        else $error("extra page access without access bit");

    AST_CACHE_RUN: assert property (@(posedge clk_sys_i) // R2
        disable iff (!rst_n_i)
        cache_o.we && !s_r.cs3 &&
        ($past(cache_o.we, 2) || $past(cache_o.we, 3))
        |-> cache_o.col == 12'($past(cache_o.col) + 12'h001))
        else $error("cache column not consecutive");

endmodule : snf_core

/* core/snf_pkg.sv */
package snf_pkg;

typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_PROG  = 5'h04,
    ST_ERASE = 5'h08,
    ST_RESET = 5'h10
} snf_state_t;

typedef enum logic [1:0] {
    ARR_READ  = 2'h0,
    ARR_PROG  = 2'h1,
    ARR_ERASE = 2'h2,
    ARR_LOCK  = 2'h3
} snf_arr_kind_t;

// Request to the array: one-cycle req, abort on soft reset
typedef struct packed {
    logic req;
    logic abort;
    snf_arr_kind_t kind;
    logic extra;
    logic [15:0] row;
} snf_arr_cmd_t;

typedef struct packed {
    logic we;
    logic [11:0] col;
    logic [7:0] data;
} snf_cache_wr_t;

typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic tg1;
    logic tg2;
    logic tg3;
    logic nv1;
    logic nv2;
    snf_state_t state;
    logic [19:0] tmr;
    logic [7:0] op;
    logic [1:0] idx;
    logic [7:0] hold;
    logic [7:0] faddr;
    logic [11:0] col;
    logic [7:0] lock;
    logic [7:0] cfg;
    logic [1:0] drv;
    logic write_enable_latch;
    logic otp_locked;
    logic busy;
    snf_cache_wr_t cache;
    snf_arr_cmd_t arr;
    logic [31:0] mirror;
} snf_sys_t;

typedef struct packed {
    logic tog;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic [31:0] mir1;
    logic [31:0] mir2;
} snf_link_t;

typedef struct packed {
    logic [6:0] shift;
    logic [2:0] bits;
    logic [1:0] idx;
    logic [7:0] op;
    logic [7:0] fa;
} snf_frame_t;

endpackage : snf_pkg

/* verif/snf_host_model.sv */
`timescale 1ns/1ps
module snf_host_model (
    // Link to the device
    output logic spi_clk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i
);
    // Select starts low so the frame logic sees the reset edge
    initial begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b0;
        spi_mosi_o = 1'b1;
        #2 spi_cs_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One frame: bytes out MSB first, then rd_n bits read back
    // Clock stands still between frames; released data line keeps toggling
    task automatic frame(input logic [7:0] b[$], input int rd_n,
                         output logic [7:0] rd);
        rd = 8'h00;
        spi_cs_n_o = 1'b0;
        #10;
        foreach (b[k]) begin
            for (int i = 7; i >= 0; i--) begin
                spi_mosi_o = b[k][i];
                #3 spi_clk_o = 1'b1;
                #3 spi_clk_o = 1'b0;
            end
        end
        repeat (rd_n) begin
            spi_mosi_o = ~spi_mosi_o;
            #3 spi_clk_o = 1'b1;
            rd = {rd[6:0], spi_miso_i};
            #3 spi_clk_o = 1'b0;
        end
        #3 spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
        // Gap well above the 80 ns needed between frames
        #120;
    endtask : frame
endmodule : snf_host_model

/* verif/test_spi_nand_erase_protect_otp.sv */
`timescale 1ns/1ps
module test_spi_nand_erase_protect_otp;
    import snf_pkg::*;
    localparam int ERS_CYC = 40;
    localparam logic [7:0] LK [8] = '{8'h08, 8'h08, 8'h0C, 8'h0C,
                                      8'h32, 8'h32, 8'h2A, 8'h2A};
    localparam logic [15:0] RW [8] = '{16'hFC00, 16'hFBC0, 16'h03C0,
        16'h0400, 16'h0000, 16'h0040, 16'hC000, 16'hBFC0};
    localparam logic OK [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
                                1'b1, 1'b0};
    logic clk_sys = 1'b0;
    logic rst_n;
    logic otp_nv = 1'b0;
    wire logic spi_clk, spi_cs_n, spi_mosi, spi_miso;
    logic busy;
    logic miso_oe;
    int oe_n = 0;
    logic busy_q = 1'b0;
    snf_cache_wr_t cache;
    snf_cache_wr_t wq[$];
    snf_arr_cmd_t arr, last_arr;
    int req_n = 0, abort_n = 0, bcnt = 0, blen = 0;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [7:0] d;

    always #10 clk_sys = ~clk_sys;

    snf_core #(.ERS_CYC(ERS_CYC), .PRG_CYC(30), .RD_CYC(20)) u_snf_core (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .spi_clk_i(spi_clk),
        .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi),
        .spi_miso_o(spi_miso), .spi_miso_oe_o(miso_oe),
        .otp_lock_nv_i(otp_nv),
        .busy_o(busy), .cache_o(cache), .arr_o(arr));

    snf_host_model u_snf_host_model (.spi_clk_o(spi_clk),
        .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
        .spi_miso_i(spi_miso));

    ////////////////////////////////////////////////////////////////////////
    // Array side: busy span restarts at an abort
    always @(posedge clk_sys) begin
        busy_q <= busy;
        bcnt <= (busy === 1'b1 && arr.abort !== 1'b1) ? bcnt + 1 : 0;
        if (busy_q === 1'b1 && busy !== 1'b1) blen <= bcnt;
        if (arr.req === 1'b1) begin
            req_n <= req_n + 1;
            last_arr <= arr;
        end
        if (arr.abort === 1'b1) abort_n <= abort_n + 1;
        if (cache.we === 1'b1) wq.push_back(cache);
    end

    // Read-back enable must cover exactly the data bits of a status read
    always @(posedge spi_clk) begin
        if (miso_oe === 1'b1) oe_n <= oe_n + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] b[$]);
        logic [7:0] unused;
        u_snf_host_model.frame(b, 0, unused);
    endtask : cmd

    task automatic getf(input logic [7:0] fa, output logic [7:0] v);
        int n;
        n = oe_n;
        u_snf_host_model.frame({8'h0F, fa}, 8, v);
        chk(oe_n == n + 8, "read-back enable span");
    endtask : getf

    task automatic wait_idle();
        int i;
        i = 0;
        @(posedge clk_sys);
        while (busy !== 1'b0 && i < 1000) begin
            @(posedge clk_sys);
            i++;
        end
        chk(busy === 1'b0, "busy stuck");
        @(posedge clk_sys);
    endtask : wait_idle

    // Row command with optional write enable; ok says whether it is taken
    task automatic exec(input logic [7:0] op, input logic [15:0] row,
                        input logic wen, input logic ok,
                        input snf_arr_kind_t k, input logic ex);
        int n;
        n = req_n;
        if (wen) cmd({8'h06});
        cmd({op, 8'h00, row[15:8], row[7:0]});
        repeat (2) @(posedge clk_sys);
        chk(req_n == n + ok, "request count");
        if (ok) chk(last_arr.kind === k && (k == ARR_LOCK ||
            last_arr.extra === ex) && last_arr.row ===
            (k == ARR_ERASE ? row & 16'hFFC0 : row), "request fields");
        wait_idle();
        if (ok && k == ARR_ERASE) chk(blen >= ERS_CYC &&
            blen <= ERS_CYC + 1, "erase busy span");
        getf(8'hC0, d);
        chk(d[1] === 1'b0, "write enable left set");
    endtask : exec

    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        getf(8'hA0, d);
        chk(d === 8'h38, "lock reset value");
        getf(8'hB0, d);
        chk(d === 8'h00, "config reset value");
        exec(8'hD8, 16'h8000, 1, 0, ARR_ERASE, 0);
        cmd({8'h1F, 8'hA0, 8'h00});
        exec(8'hD8, 16'h8000, 0, 0, ARR_ERASE, 0);
        exec(8'hD8, 16'h807F, 1, 1, ARR_ERASE, 0);
        for (int i = 0; i < 8; i++) begin
            cmd({8'h1F, 8'hA0, LK[i]});
            getf(8'hA0, d);
            chk(d === LK[i], "lock readback");
            exec(8'hD8, RW[i], 1, OK[i], ARR_ERASE, 0);
        end
        cmd({8'h1F, 8'hA0, 8'h00});
        cmd({8'h06});
        cmd({8'hD8, 8'h00, 8'h12, 8'h00});
        cmd({8'hFF});
        wait_idle();
        chk(abort_n == 1 && blen >= 245 && blen <= 255, "reset abort");
        cmd({8'h1F, 8'hA0, 8'h00});
        wq.delete();
        cmd({8'h84, 8'h01, 8'h23, 8'hAA, 8'h55});
        cmd({8'h84, 8'h08, 8'h7F, 8'h11, 8'h22});
        repeat (4) @(posedge clk_sys);
        chk(wq.size() == 3, "cache write count");
        chk(wq[0] === {1'b1, 12'h123, 8'hAA} && wq[1] === {1'b1, 12'h124,
            8'h55} && wq[2] === {1'b1, 12'h87F, 8'h11}, "cache data");
        cmd({8'h02, 8'h00, 8'h05, 8'h66});
        repeat (4) @(posedge clk_sys);
        chk(wq.size() == 4 && wq[3] === {1'b1, 12'h005, 8'h66},
            "plain load data");
        exec(8'h13, 16'h1234, 0, 1, ARR_READ, 0);
        cmd({8'h84, 8'h00, 8'h10, 8'h5A});
        exec(8'h10, 16'h1234, 0, 0, ARR_PROG, 0);
        exec(8'h10, 16'h1234, 1, 1, ARR_PROG, 0);
        cmd({8'h1F, 8'hB0, 8'h40});
        exec(8'h10, 16'h0002, 1, 1, ARR_PROG, 1);
        exec(8'h10, 16'h0000, 1, 0, ARR_PROG, 1);
        exec(8'h10, 16'h001B, 1, 0, ARR_PROG, 1);
        exec(8'hD8, 16'h0040, 1, 0, ARR_ERASE, 1);
        cmd({8'h1F, 8'hB0, 8'hC0});
        exec(8'h10, 16'h0000, 1, 1, ARR_LOCK, 1);
        @(posedge clk_sys);
        #1 otp_nv = 1'b1;
        exec(8'h10, 16'h0003, 1, 0, ARR_PROG, 1);
        cmd({8'h1F, 8'hB0, 8'h40});
        getf(8'hB0, d);
        chk(d === 8'hC0, "lock bit not set");
        exec(8'h10, 16'h0003, 1, 0, ARR_PROG, 1);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        getf(8'hB0, d);
        chk(d === 8'h80, "lock bit lost at reset");
        cmd({8'h1F, 8'hA0, 8'h00});
        cmd({8'h1F, 8'hB0, 8'h00});
        exec(8'h10, 16'h0003, 1, 1, ARR_PROG, 0);
        end_sim();
    end

    // Whole sequence needs well under 100 us
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
endmodule : test_spi_nand_erase_protect_otp
